/* verilog/flash_instruction_decoder.sv */
// Instruction decoder and array logic for two flash arrays
// Notes on behaviour
// - Address at strobe fall, data at rise
// - Sector selects active high, name sector
// - Only address bits eleven to zero compared
// - Query and error states held until reset
// - Protection read gives 00h or 01h
// - Bypass program only in bypass mode
// - Bypass left only by bypass reset
// - Suspend only during sector erase
// - Resume only when suspended, else ignored
// - Bytes decoded in sequence, gap limited
// - Bad byte or timeout returns to read, or to bypass or suspend mode while that is active
// - Two unlock cycles precede program outside bypass mode, query, erase and bypass entry
// - High address bits ignored, select needed
// - Selects route instruction to either array
// - Read mode after reset, or after reset instruction unless bypass or suspend mode is active
// - Plain reads return array contents
// - Identifier read on primary array only
// - Error flag set on failed program
// - Poll bit zero during erase, then one
// - Toggle bit flips on each busy read
// - Window bit zero while window open, until a further sector is added
`timescale 1ns/10ps
`default_nettype none
module flash_instruction_decoder #(
  parameter int OFFW = 4,
  parameter int PROG_CYCLES = 100,
  parameter int ERASE_CYCLES = 1000,
  parameter logic [7:0] ID_VALUE = 8'h5a // Arbitrary identifier value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host memory bus pins
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_din,
  output logic [15:0] bus_dout,
  output logic bus_oe,
  input wire logic low_byte_write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] primary_sector_selects,
  input wire logic [3:0] secondary_sector_selects,
  // Wishbone register slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o
);
  import flash_decoder_pkg::*;

  localparam int IW = OFFW + 4;
  localparam int DEPTH = 1 << IW;

  // ----------------------------------------------------------------------
  // Pin synchronisers and strobe edges
  // ----------------------------------------------------------------------
  logic [45:0] pin_raw;
  logic [45:0] sync1_q;
  logic [45:0] sync2_q;
  logic wr_prev_q;
  logic rd_prev_q;
  assign pin_raw = {bus_addr, bus_din, primary_sector_selects,
                    secondary_sector_selects, low_byte_write_strobe_n,
                    read_strobe_n};

  // Two flip-flops ahead of any logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= PIN_RESET;
      sync2_q <= PIN_RESET;
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      wr_prev_q <= sync2_q[1];
      rd_prev_q <= sync2_q[0];
    end
  end

  logic [15:0] s_addr;
  logic [15:0] s_din;
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  assign s_addr = sync2_q[45:30];
  assign s_din = sync2_q[29:14];
  assign wr_fall = wr_prev_q & ~sync2_q[1];
  assign wr_rise = ~wr_prev_q & sync2_q[1];
  assign rd_fall = rd_prev_q & ~sync2_q[0];

  // Selects to {valid, bank, sector}; primary wins if both are high
  function automatic logic [4:0] sel_decode(input logic [7:0] p,
                                            input logic [3:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 7; i >= 0; i--) begin
      if (i < 4 && s[2'(i)] && p == 8'h00) begin
        r = {2'b11, 3'(i)};
      end
      if (p[i]) begin
        r = {2'b10, 3'(i)};
      end
    end
    return r;
  endfunction

  logic [4:0] rsel;
  assign rsel = sel_decode(sync2_q[13:6], sync2_q[5:2]);

  // ----------------------------------------------------------------------
  // Address and select captured at the write strobe fall
  // ----------------------------------------------------------------------
  logic [15:0] pa_q;
  logic [4:0] wsel_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pa_q <= 16'h0000;
      wsel_q <= 5'h00;
    end else if (wr_fall) begin
      pa_q <= s_addr;
      wsel_q <= sel_decode(sync2_q[13:6], sync2_q[5:2]);
    end
  end

  // ----------------------------------------------------------------------
  // Decoder signals
  // ----------------------------------------------------------------------
  state_t state_q;
  state_t home;
  logic bypass_q;
  logic susp_q;
  logic bulk_q;
  logic bank_q;
  logic prog_err_q;
  logic more_q;
  logic [15:0] mask_q;
  logic [15:0] protect_q;
  logic [IW-1:0] prog_idx_q;
  logic [15:0] prog_data_q;
  logic [15:0] gap_cnt_q;
  logic [15:0] win_cnt_q;
  logic [15:0] ecnt_q;
  logic [15:0] pcnt_q;
  logic [15:0] mem [0:DEPTH-1];
  logic wr_ev;
  logic [7:0] cmd;
  logic at_cmd;
  logic is_ul1;
  logic is_ul2;
  logic in_seq;
  logic [3:0] wsect;
  logic [IW-1:0] widx;
  logic prog_done;
  logic erase_done;

  assign wr_ev = wr_rise & wsel_q[4];
  assign cmd = s_din[7:0];
  assign at_cmd = pa_q[11:0] == ADDR_UNLOCK1;
  assign is_ul1 = at_cmd && cmd == CMD_UNLOCK1;
  assign is_ul2 = pa_q[11:0] == ADDR_UNLOCK2 && cmd == CMD_UNLOCK2;
  assign wsect = wsel_q[3:0];
  assign widx = {wsect, pa_q[OFFW:1]};
  assign prog_done = state_q == S_PBUSY && pcnt_q == 16'(PROG_CYCLES - 1);
  assign erase_done = state_q == S_EBUSY && ecnt_q == 16'(ERASE_CYCLES - 1);
  assign home = bypass_q ? S_BYP : (susp_q ? S_SUSP : S_READ);
  assign in_seq = state_q inside {S_UL1, S_UL2, S_PROG, S_ER1, S_ER2,
                                  S_ER3, S_BYP_PROG, S_BYP_EXIT};

  // Inter-byte gap counter, restarted by every write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_cnt_q <= 16'h0000;
    end else if (wr_rise) begin
      gap_cnt_q <= 16'h0000;
    end else if (gap_cnt_q != 16'(GAP_CYCLES)) begin
      gap_cnt_q <= gap_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_READ;
      bypass_q <= 1'b0;
      susp_q <= 1'b0;
      bulk_q <= 1'b0;
      bank_q <= 1'b0;
      prog_err_q <= 1'b0;
      more_q <= 1'b0;
      mask_q <= 16'h0000;
      prog_idx_q <= '0;
      prog_data_q <= 16'h0000;
      win_cnt_q <= 16'h0000;
      ecnt_q <= 16'h0000;
      pcnt_q <= 16'h0000;
    end else if (in_seq && gap_cnt_q == 16'(GAP_CYCLES) && !wr_rise) begin
      state_q <= home;
    end else begin
      case (state_q)
        S_READ, S_SUSP: begin
          if (wr_ev && is_ul1) begin
            state_q <= S_UL1;
            bank_q <= wsel_q[3];
          end else if (wr_ev && state_q == S_SUSP && cmd == CMD_SECTOR) begin
            state_q <= S_EBUSY;
            susp_q <= 1'b0;
          end
        end
        S_UL1: if (wr_ev) state_q <= is_ul2 ? S_UL2 : home;
        S_UL2: begin
          if (wr_ev) begin
            state_q <= home;
            if (at_cmd && cmd == CMD_PROGRAM) begin
              state_q <= S_PROG;
            end else if (at_cmd && cmd == CMD_QUERY) begin
              state_q <= S_QUERY;
            end else if (at_cmd && cmd == CMD_ERASE && !susp_q) begin
              state_q <= S_ER1;
            end else if (at_cmd && cmd == CMD_BYPASS && !susp_q) begin
              state_q <= S_BYP;
              bypass_q <= 1'b1;
            end
          end
        end
        S_PROG, S_BYP_PROG: begin
          if (wr_ev) begin
            if (protect_q[wsect] || (susp_q && mask_q[wsect])) begin
              state_q <= home;
            end else begin
              state_q <= S_PBUSY;
              bank_q <= wsel_q[3];
              pcnt_q <= 16'h0000;
              prog_idx_q <= widx;
              prog_data_q <= s_din;
              prog_err_q <= |(~mem[widx] & s_din);
            end
          end
        end
        S_ER1: if (wr_ev) state_q <= is_ul1 ? S_ER2 : home;
        S_ER2: if (wr_ev) state_q <= is_ul2 ? S_ER3 : home;
        S_ER3: begin
          if (wr_ev && cmd == CMD_SECTOR) begin
            state_q <= S_WINDOW;
            mask_q <= 16'h0001 << wsect;
            win_cnt_q <= 16'h0000;
            bulk_q <= 1'b0;
            more_q <= 1'b0;
          end else if (wr_ev && at_cmd && cmd == CMD_BULK) begin
            state_q <= S_EBUSY;
            mask_q <= wsel_q[3] ? 16'hff00 : 16'h00ff;
            ecnt_q <= 16'h0000;
            bulk_q <= 1'b1;
          end else if (wr_ev) begin
            state_q <= home;
          end
        end
        S_WINDOW: begin
          win_cnt_q <= win_cnt_q + 16'h0001;
          if (wr_ev && cmd == CMD_SECTOR) begin
            mask_q <= mask_q | (16'h0001 << wsect);
            more_q <= 1'b1;
            win_cnt_q <= 16'h0000;
          end else if (wr_ev) begin
            state_q <= home;
            mask_q <= 16'h0000;
          end else if (win_cnt_q == 16'(WINDOW_CYCLES - 1)) begin
            state_q <= S_EBUSY;
            ecnt_q <= 16'h0000;
          end
        end
        S_EBUSY: begin
          ecnt_q <= ecnt_q + 16'h0001;
          if (erase_done) begin
            state_q <= home;
            mask_q <= 16'h0000;
          end else if (wr_ev && cmd == CMD_SUSPEND && !bulk_q) begin
            state_q <= S_SUSP;
            susp_q <= 1'b1;
          end
        end
        S_PBUSY: begin
          pcnt_q <= pcnt_q + 16'h0001;
          if (prog_done) state_q <= prog_err_q ? S_ERROR : home;
        end
        S_QUERY, S_ERROR: begin
          if (wr_ev && cmd == CMD_RESET) state_q <= home;
        end
        S_BYP: begin
          if (wr_ev && cmd == CMD_PROGRAM) begin
            state_q <= S_BYP_PROG;
          end else if (wr_ev && cmd == CMD_QUERY) begin
            state_q <= S_BYP_EXIT;
          end
        end
        S_BYP_EXIT: begin
          if (wr_ev && cmd == CMD_BYPASS_EXIT) begin
            state_q <= S_READ;
            bypass_q <= 1'b0;
          end else if (wr_ev) begin
            state_q <= S_BYP;
          end
        end
        default: state_q <= S_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Array storage: program commit and erase walk
  // ----------------------------------------------------------------------
  initial begin
    for (int i = 0; i < DEPTH; i++) mem[i] = ERASED_WORD;
  end

  always @(posedge clk) begin
    if (prog_done && !prog_err_q) begin
      mem[prog_idx_q] <= prog_data_q;
    end else if (state_q == S_EBUSY && ecnt_q < 16'(DEPTH)) begin
      if (mask_q[ecnt_q[IW-1:OFFW]] && !protect_q[ecnt_q[IW-1:OFFW]]) begin
        mem[ecnt_q[IW-1:0]] <= ERASED_WORD;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path: array, status byte, identifier and protection
  // ----------------------------------------------------------------------
  logic toggle_q;
  logic status_rd;
  logic [7:0] st_byte;
  logic [3:0] rsect;
  assign rsect = rsel[3:0];
  assign status_rd = (state_q == S_PBUSY || state_q == S_ERROR ||
                      state_q == S_EBUSY || state_q == S_WINDOW) &&
                     rsel[3] == bank_q;
  assign st_byte = {
    (state_q == S_PBUSY || state_q == S_ERROR) ? ~prog_data_q[7] : 1'b0,
    toggle_q,
    state_q == S_ERROR,
    1'b0,
    state_q != S_WINDOW || more_q,
    3'h0};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_dout <= 16'h0000;
      bus_oe <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      bus_oe <= ~sync2_q[0] & rsel[4];
      if (rd_fall && rsel[4]) begin
        bus_dout <= mem[{rsect, s_addr[OFFW:1]}];
        if (status_rd) begin
          bus_dout <= {st_byte, st_byte};
          toggle_q <= ~toggle_q;
        end else if (state_q == S_QUERY && rsel[3] == bank_q) begin
          if (s_addr[1:0] == ADDR_PROTECT) begin
            bus_dout <= {15'h0000, protect_q[rsect]};
          end else if (s_addr[1:0] == ADDR_ID && !bank_q) begin
            bus_dout <= {8'h00, ID_VALUE};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave: protection and status registers
  // ----------------------------------------------------------------------
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_PROG_BUSY] = state_q == S_PBUSY;
    status_word[ST_ERASE_BUSY] = state_q == S_EBUSY;
    status_word[ST_SUSPENDED] = susp_q;
    status_word[ST_BYPASS] = bypass_q;
    status_word[ST_ERROR] = state_q == S_ERROR;
    status_word[ST_QUERY] = state_q == S_QUERY;
    status_word[ST_WINDOW] = state_q == S_WINDOW;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      protect_q <= PROTECT_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_adr_i == REG_PROTECT) begin
          wb_dat_o <= {16'h0000, protect_q};
          if (wb_we_i && wb_sel_i[0]) protect_q[7:0] <= wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1]) protect_q[15:8] <= wb_dat_i[15:8];
        end else if (wb_adr_i == REG_STATUS) begin
          wb_dat_o <= status_word;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/flash_decoder_pkg.sv */
// Constants, commands and states of the flash instruction decoder
package flash_decoder_pkg;
  // ----------------------------------------------------------------------
  // Timing at a 10 MHz clock
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int GAP_TIMEOUT_NS = 50000;
  localparam int ERASE_WINDOW_NS = 100000;
  localparam int GAP_CYCLES = GAP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int WINDOW_CYCLES = ERASE_WINDOW_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------------
  // Instruction bytes and addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_QUERY = 8'h90;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'haaa;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h554;
  localparam logic [1:0] ADDR_ID = 2'h1;
  localparam logic [1:0] ADDR_PROTECT = 2'h2;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // ----------------------------------------------------------------------
  // Wishbone register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_PROTECT = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [15:0] PROTECT_RESET = 16'h0000;
  localparam logic [45:0] PIN_RESET = 46'h3;
  localparam int ST_PROG_BUSY = 0;
  localparam int ST_ERASE_BUSY = 1;
  localparam int ST_SUSPENDED = 2;
  localparam int ST_BYPASS = 3;
  localparam int ST_ERROR = 4;
  localparam int ST_QUERY = 5;
  localparam int ST_WINDOW = 6;
  // ----------------------------------------------------------------------
  // Decoder states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_READ, S_UL1, S_UL2, S_PROG, S_ER1, S_ER2, S_ER3, S_WINDOW,
    S_EBUSY, S_PBUSY, S_SUSP, S_QUERY, S_ERROR, S_BYP, S_BYP_PROG,
    S_BYP_EXIT
  } state_t;
endpackage

/* verification/flash_decoder_chk.sv */
// Port checker of the flash instruction decoder
`timescale 1ns/10ps
`default_nettype none
module flash_decoder_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host bus pins
  input wire logic [15:0] bus_dout,
  input wire logic bus_oe,
  input wire logic read_strobe_n,
  input wire logic [7:0] primary_sector_selects,
  input wire logic [3:0] secondary_sector_selects,
  // Wishbone slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  import flash_decoder_pkg::*;
  logic [15:0] prot_q;
  logic rd_ack;
  logic any_sel;
  // Read answer and select summary
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign any_sel = |primary_sector_selects || |secondary_sector_selects;
  // Shadow of the protection register, lanes 0 and 1
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prot_q <= PROTECT_RESET;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == REG_PROTECT) begin
      if (wb_sel_i[0]) begin
        prot_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        prot_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_idle;
    read_strobe_n [*5];
  endsequence
  sequence rd_held;
    $fell(read_strobe_n) && any_sel ##1 (!read_strobe_n && any_sel) [*5];
  endsequence
  ack_answers_req_a: assert property (wb_req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i))
    else $error("ack without request");
  dat_zero_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  unmapped_zero_a: assert property (rd_ack && wb_adr_i != REG_PROTECT
    && wb_adr_i != REG_STATUS |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  prot_readback_a: assert property (rd_ack && wb_adr_i == REG_PROTECT
    |-> wb_dat_o == {16'h0000, prot_q})
    else $error("protection readback wrong");
  status_spare_a: assert property (rd_ack && wb_adr_i == REG_STATUS
    |-> wb_dat_o[31:7] == '0)
    else $error("status spare bits set");
  oe_idle_off_a: assert property (rd_idle |-> !bus_oe)
    else $error("bus driven without read");
  oe_read_on_a: assert property (rd_held |-> bus_oe)
    else $error("bus not driven in read");
  dout_hold_a: assert property (rd_idle |-> $stable(bus_dout))
    else $error("read data moved while idle");
endmodule
bind flash_instruction_decoder flash_decoder_chk flash_decoder_chk_i (
  .clk(clk), .resetn(resetn), .bus_dout(bus_dout), .bus_oe(bus_oe),
  .read_strobe_n(read_strobe_n),
  .primary_sector_selects(primary_sector_selects),
  .secondary_sector_selects(secondary_sector_selects),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* verification/host_model.sv */
// Host microcontroller model on the flash bus pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Flash bus pins
  input wire logic [15:0] bus_dout,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_din,
  output logic low_byte_write_strobe_n,
  output logic read_strobe_n,
  output logic [7:0] primary_sector_selects,
  output logic [3:0] secondary_sector_selects
);
  // Power-up pins: strobes high, selects low
  initial begin
    bus_addr = '0;
    bus_din = '0;
    low_byte_write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    primary_sector_selects = '0;
    secondary_sector_selects = '0;
  end
  // One bus cycle; each strobe level held well past the pin sync
  task automatic acc(input logic wr, input logic [15:0] a, d,
                     input logic [11:0] s, output logic [15:0] q);
    @(posedge clk);
    bus_addr <= a;
    bus_din <= d;
    primary_sector_selects <= s[7:0];
    secondary_sector_selects <= s[11:8];
    repeat (2) @(posedge clk);
    if (wr) begin
      low_byte_write_strobe_n <= 1'b0;
    end else begin
      read_strobe_n <= 1'b0;
    end
    repeat (6) @(posedge clk);
    q = bus_dout;
    low_byte_write_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    repeat (5) @(posedge clk);
    // Released address and data lines show the inverse of the last value, selects go low
    bus_addr <= ~a;
    bus_din <= ~d;
    primary_sector_selects <= '0;
    secondary_sector_selects <= '0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench of the flash instruction decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import flash_decoder_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
  localparam logic [11:0] S0 = 12'h001;
  localparam logic [11:0] S1 = 12'h002;
  localparam logic [11:0] B0 = 12'h100;
  logic clk, resetn, oe, wn, rn, we, cyc, stb, ack;
  logic [15:0] ad, di, dq;
  logic [7:0] ps, adr;
  logic [3:0] ss, sel;
  logic [31:0] wdat, rdat;
  int error_cnt;
  int tests_run;
  flash_instruction_decoder #(.PROG_CYCLES(60), .ERASE_CYCLES(300),
    .ID_VALUE(ID)) flash_instruction_decoder_i (.clk(clk),
    .resetn(resetn), .bus_addr(ad), .bus_din(di), .bus_dout(dq),
    .bus_oe(oe), .low_byte_write_strobe_n(wn), .read_strobe_n(rn),
    .primary_sector_selects(ps), .secondary_sector_selects(ss),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack));
  host_model host_i (.clk(clk), .bus_dout(dq), .bus_addr(ad),
    .bus_din(di), .low_byte_write_strobe_n(wn), .read_strobe_n(rn),
    .primary_sector_selects(ps), .secondary_sector_selects(ss));
  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Verdict and end of run
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Compares of bus words and register words
  task automatic chk16(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk32(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Classic Wishbone cycle, bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  // Masked status register compare
  task automatic st(input logic [31:0] e, m);
    logic [31:0] q;
    wb(1'b0, REG_STATUS, '0, 4'hf, q);
    chk32("status", e, q & m);
  endtask
  // Host write, read and unlocked instruction
  task automatic hw(input logic [15:0] a, d, input logic [11:0] s);
    logic [15:0] q;
    host_i.acc(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [11:0] s,
                    output logic [15:0] q);
    host_i.acc(1'b0, a, 16'h0000, s, q);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [11:0] s);
    hw(16'h3aaa, 16'h00aa, s);
    hw(16'hc554, 16'h0055, s);
    hw(16'h5aaa, {8'h00, c}, s);
  endtask
  // Wait until program, erase and window are over
  task automatic idle;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, '0, 4'hf, q);
      n++;
    end while ((q & 32'h43) !== 32'h0 && n < 2000);
    if (n == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  // Register reset values, byte lanes, unmapped place
  task automatic t_regs;
    logic [31:0] q;
    wb(1'b0, REG_PROTECT, '0, 4'hf, q);
    chk32("protect", {16'h0000, PROTECT_RESET}, q);
    st(32'h0, 32'h7f);
    wb(1'b1, REG_PROTECT, 32'habcd_1202, 4'h1, q);
    wb(1'b1, 8'h08, 32'hffff_ffff, 4'hf, q);
    wb(1'b0, 8'h08, '0, 4'hf, q);
    chk32("unmapped", 32'h0, q);
    wb(1'b0, REG_PROTECT, '0, 4'hf, q);
    chk32("protect", 32'h2, q);
  endtask
  // Program with status polling, then protected and faulty programs
  task automatic t_prog;
    logic [15:0] q, p;
    rd(16'h7002, S0, q);
    chk16("erased", 16'hffff, q);
    cmd(CMD_PROGRAM, S0);
    hw(16'h7002, 16'h1234, S0);
    rd(16'h7002, S0, q);
    rd(16'h7002, S0, p);
    chk16("poll", 16'h0080, q & 16'h00a0);
    chk16("toggle", 16'h0040, (q ^ p) & 16'h0040);
    idle;
    rd(16'h7002, S0, q);
    chk16("word", 16'h1234, q);
    cmd(CMD_PROGRAM, S1);
    hw(16'h0004, 16'h0000, S1);
    idle;
    rd(16'h0004, S1, q);
    chk16("locked", 16'hffff, q);
    cmd(CMD_PROGRAM, S0);
    hw(16'h7002, 16'hffff, S0);
    idle;
    st(32'h1 << ST_ERROR, 32'h7f);
    hw(16'h0000, {8'h00, CMD_RESET}, S0);
    st(32'h0, 32'h7f);
  endtask
  // Identifier and protection queries
  task automatic t_query;
    logic [15:0] q;
    cmd(CMD_QUERY, S0);
    rd(16'h0001, S0, q);
    chk16("ident", {8'h00, ID}, q & 16'h00ff);
    rd(16'h0002, S1, q);
    chk16("protected", 16'h0001, q & 16'h00ff);
    rd(16'h0002, S0, q);
    chk16("open", 16'h0000, q & 16'h00ff);
    st(32'h1 << ST_QUERY, 32'h7f);
    hw(16'h0000, {8'h00, CMD_RESET}, S0);
    rd(16'h7002, S0, q);
    chk16("after reset", 16'h1234, q);
  endtask
  // Bypass programming on the secondary array
  task automatic t_bypass;
    logic [15:0] q;
    cmd(CMD_BYPASS, B0);
    st(32'h1 << ST_BYPASS, 32'h7f);
    hw(16'h0000, {8'h00, CMD_PROGRAM}, B0);
    hw(16'h000a, 16'h00f0, B0);
    idle;
    rd(16'h000a, B0, q);
    chk16("bypass word", 16'h00f0, q);
    rd(16'h000a, S0, q);
    chk16("other array", 16'hffff, q);
    hw(16'h0000, {8'h00, CMD_QUERY}, B0);
    hw(16'h0000, {8'h00, CMD_BYPASS_EXIT}, B0);
    st(32'h0, 32'h7f);
  endtask
  // Stray suspend and resume, gap timeout, bad unlock address
  task automatic t_abort;
    logic [15:0] q;
    hw(16'h0000, {8'h00, CMD_SUSPEND}, S0);
    hw(16'h0000, {8'h00, CMD_SECTOR}, S0);
    st(32'h0, 32'h7f);
    hw(16'h0aaa, 16'h00aa, S0);
    repeat (GAP_CYCLES + 10) @(posedge clk);
    hw(16'h0554, 16'h0055, S0);
    hw(16'h0aaa, {8'h00, CMD_PROGRAM}, S0);
    hw(16'h0006, 16'h0000, S0);
    st(32'h0, 32'h7f);
    hw(16'h0aaa, 16'h00aa, S0);
    hw(16'h0556, 16'h0055, S0);
    hw(16'h0aaa, {8'h00, CMD_PROGRAM}, S0);
    hw(16'h0006, 16'h0000, S0);
    rd(16'h0006, S0, q);
    chk16("aborted", 16'hffff, q);
  endtask
  // Sector erase with window, suspend and resume
  task automatic t_erase;
    logic [15:0] q;
    cmd(CMD_ERASE, S0);
    cmd(CMD_SECTOR, S0);
    rd(16'h7002, S0, q);
    chk16("window", 16'h0000, q & 16'h0088);
    hw(16'h0000, {8'h00, CMD_SECTOR}, S0);
    rd(16'h7002, S0, q);
    chk16("more", 16'h0008, q & 16'h0088);
    repeat (WINDOW_CYCLES + 20) @(posedge clk);
    rd(16'h7002, S0, q);
    chk16("erasing", 16'h0008, q & 16'h0088);
    hw(16'h0000, {8'h00, CMD_SUSPEND}, S0);
    st(32'h1 << ST_SUSPENDED, 32'h4);
    rd(16'h0004, S1, q);
    chk16("other sector", 16'hffff, q);
    hw(16'h0000, {8'h00, CMD_SECTOR}, S0);
    st(32'h0, 32'h4);
    idle;
    rd(16'h7002, S0, q);
    chk16("erased word", 16'hffff, q);
    cmd(CMD_ERASE, B0);
    cmd(CMD_BULK, B0);
    idle;
    rd(16'h000a, B0, q);
    chk16("bulk", 16'hffff, q);
  endtask
  // Reset, then the scenarios in order
  initial begin
    resetn = 1'b0;
    {cyc, stb, we, adr, wdat, sel} = '0;
    error_cnt = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_prog;
    t_query;
    t_bypass;
    t_abort;
    t_erase;
    report_and_stop;
  end
endmodule
`default_nettype wire
